/* core/dmp_pkg.sv */
// package: constants and types for the display memory port
package dmp_pkg;
    // memory cycle phase lengths in dot clocks
    localparam int unsigned ROW_SETUP_CYC  = 1;
    localparam int unsigned RAS_HOLD_CYC   = 2;
    localparam int unsigned CAS_CYC        = 2;
    localparam int unsigned PHASE_CNT_W    = 3;
    localparam logic [2:0]  PHASE_ONE      = 3'h1;
    localparam logic [2:0]  PHASE_ZERO     = 3'h0;
    // ready drives high for one dot clock before floating
    localparam int unsigned RDY_HIGH_CYC   = 1;
    // plane index of the font plane
    localparam int unsigned FONT_PLANE     = 2;
    localparam logic [3:0]  FONT_PLANE_MASK = 4'h4;
    localparam logic [3:0]  ALL_PLANES_OFF  = 4'hf;
    localparam logic [7:0]  BYTE_ZERO       = 8'h00;
    // memory cycle kinds and states
    typedef enum logic [1:0] {
        KIND_REFRESH,
        KIND_HOST_RD,
        KIND_HOST_WR
    } kind_t;
    typedef enum logic [2:0] {
        ST_IDLE,
        ST_EARLY,
        ST_ROW,
        ST_COL,
        ST_DONE
    } state_t;
endpackage

/* core/mem_bus_if.sv */
// interface: one plane-pair multiplexed bus between top and bus driver
`timescale 1ns/1ns
interface mem_bus_if;
    logic [7:0] row_addr;
    logic [7:0] col_addr;
    logic [7:0] wr_data;
    logic       sel_col;
    logic       drive_data;
    logic       drive_addr;
    logic [7:0] rd_data;
    modport ctrl (
        output row_addr,
        output col_addr,
        output wr_data,
        output sel_col,
        output drive_data,
        output drive_addr,
        input  rd_data
    );
    modport drv (
        input  row_addr,
        input  col_addr,
        input  wr_data,
        input  sel_col,
        input  drive_data,
        input  drive_addr,
        output rd_data
    );
endinterface

/* core/pair_bus.sv */
// module: address/data multiplexer for one plane-pair bus
`timescale 1ns/1ns
module pair_bus (
    input  wire logic       i_clk,
    input  wire logic       i_rst_n,
    input  wire logic       i_cap,
    input  wire logic [7:0] i_pin,
    output logic      [7:0] o_pin,
    output logic            o_pin_oe_n,
    mem_bus_if.drv          bus
);
    typedef struct packed {
        logic [7:0] out;
        logic       oe_n;
        logic [7:0] rd;
    } st_t;
    st_t st_r;
    st_t st_nxt;

    // ---------------------------------------------------------------
    // row then column address, then write data; read data captured
    // ---------------------------------------------------------------
    always_comb begin
        st_nxt = st_r;
        st_nxt.oe_n = ~(bus.drive_addr | bus.drive_data);
        if (bus.drive_data) begin
            st_nxt.out = bus.wr_data;
        end else if (bus.sel_col) begin
            st_nxt.out = bus.col_addr;
        end else begin
            st_nxt.out = bus.row_addr;
        end
        if (i_cap) begin
            st_nxt.rd = i_pin;
        end
    end

    // registered so the pins are glitch free
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            st_r <= '{out: dmp_pkg::BYTE_ZERO, oe_n: 1'b1,
                      rd: dmp_pkg::BYTE_ZERO};
        end else begin
            st_r <= st_nxt;
        end
    end

    assign o_pin      = st_r.out;
    assign o_pin_oe_n = st_r.oe_n;
    assign bus.rd_data = st_r.rd;
endmodule

/* core/display_mem_port.sv */
// module: display memory port with host ready, irq and trap pins
`timescale 1ns/1ns
module display_mem_port #(
    parameter int unsigned ADDR_W = 16
) (
    input  wire logic              i_clk,
    input  wire logic              i_rstn,
    // host side request
    input  wire logic              i_host_req,
    input  wire logic              i_host_wr,
    input  wire logic [ADDR_W-1:0] i_host_addr,
    input  wire logic [3:0]        i_host_plane_mask,
    input  wire logic [31:0]       i_host_wdata,
    output logic      [31:0]       o_host_rdata,
    output logic                   o_host_done,
    // display refresh fetch request
    input  wire logic              i_fetch_req,
    input  wire logic [ADDR_W-1:0] i_fetch_addr,
    input  wire logic              i_text_mode,
    // retrace interrupt control bits
    input  wire logic              i_irq_event,
    input  wire logic              i_irq_enable,
    input  wire logic              i_irq_clear_bit,
    input  wire logic              i_irq_clear_wr,
    // emulation trap
    input  wire logic              i_trap_is_output,
    input  wire logic              i_trap_request,
    input  wire logic              i_trap_pin,
    output logic                   o_trap_pin,
    output logic                   o_trap_pin_oe_n,
    // host bus pins
    output logic                   o_ready_n,
    output logic                   o_ready_n_oe_n,
    output logic                   o_display_irq,
    output logic                   o_display_irq_oe_n,
    // display memory pins
    input  wire logic [7:0]        i_planes01_bus,
    output logic      [7:0]        o_planes01_bus,
    output logic                   o_planes01_bus_oe_n,
    input  wire logic [7:0]        i_planes23_bus,
    output logic      [7:0]        o_planes23_bus,
    output logic                   o_planes23_bus_oe_n,
    output logic                   o_ras_n,
    output logic                   o_cas_n,
    output logic                   o_plane02_read_en_n,
    output logic                   o_plane13_read_en_n,
    output logic      [3:0]        o_plane_write_en_n,
    output logic                   o_early_mem_en_n,
    output logic                   o_attr_shift_load_n
);
    // ---------------------------------------------------------------
    // state
    // ---------------------------------------------------------------
    typedef struct packed {
        logic [1:0]           rst_sync;
        dmp_pkg::state_t      state;
        dmp_pkg::kind_t       kind;
        logic [dmp_pkg::PHASE_CNT_W-1:0] cnt;
        logic                 second;   // second read of pair
        logic [ADDR_W-1:0]    addr;
        logic [31:0]          wdata;
        logic [3:0]           wmask;
        logic [31:0]          rdata;
        logic                 done;
        logic                 ras_n;
        logic                 cas_n;
        logic                 plane02_read_en_n_n;
        logic                 plane13_read_en_n_n;
        logic [3:0]           we_n;
        logic                 early_n;
        logic                 sload_n;
        logic                 irq_pend;
        logic                 rdy_n;
        logic                 rdy_oe_n;
        logic [2:0]           trap_sync;
    } st_t;
    st_t st_r;
    st_t st_nxt;
    logic rst_n;
    logic cap;
    logic trap_low;
    mem_bus_if bus01();
    mem_bus_if bus23();

    assign rst_n = st_r.rst_sync[1];
    // pin synchroniser: stage 0 only feeds stage 1
    assign trap_low = ~st_r.trap_sync[1] & ~st_r.trap_sync[2];
    // capture in the clock after the read enable was driven
    assign cap = (st_r.state == dmp_pkg::ST_COL) && !st_r.cas_n;

    // ---------------------------------------------------------------
    // two plane-pair buses
    // ---------------------------------------------------------------
    pair_bus u_bus01 (
        .i_clk      (i_clk),
        .i_rst_n    (rst_n),
        .i_cap      (cap),
        .i_pin      (i_planes01_bus),
        .o_pin      (o_planes01_bus),
        .o_pin_oe_n (o_planes01_bus_oe_n),
        .bus        (bus01.drv)
    );
    pair_bus u_bus23 (
        .i_clk      (i_clk),
        .i_rst_n    (rst_n),
        .i_cap      (cap),
        .i_pin      (i_planes23_bus),
        .o_pin      (o_planes23_bus),
        .o_pin_oe_n (o_planes23_bus_oe_n),
        .bus        (bus23.drv)
    );

    // same address on both pairs; data lanes per plane
    always_comb begin
        bus01.row_addr   = st_r.addr[ADDR_W-1:8];
        bus01.col_addr   = st_r.addr[7:0];
        bus23.row_addr   = st_r.addr[ADDR_W-1:8];
        bus23.col_addr   = st_r.addr[7:0];
        bus01.sel_col    = (st_r.state == dmp_pkg::ST_COL) ||
                           (st_r.state == dmp_pkg::ST_ROW && st_r.cnt ==
                            dmp_pkg::PHASE_CNT_W'(dmp_pkg::RAS_HOLD_CYC));
        bus23.sel_col    = bus01.sel_col;
        bus01.drive_addr = (st_r.state == dmp_pkg::ST_ROW) ||
                           (st_r.state == dmp_pkg::ST_COL && st_r.cas_n);
        bus23.drive_addr = bus01.drive_addr;
        bus01.drive_data = (st_r.kind == dmp_pkg::KIND_HOST_WR) &&
                           (st_r.state == dmp_pkg::ST_COL) && !st_r.cas_n;
        bus23.drive_data = bus01.drive_data;
        // plane 0/1 share one bus: lane picked by which write strobe
        bus01.wr_data = st_r.wmask[0] ? st_r.wdata[7:0]
                                      : st_r.wdata[15:8];
        bus23.wr_data = st_r.wmask[2] ? st_r.wdata[23:16]
                                      : st_r.wdata[31:24];
    end

    // ---------------------------------------------------------------
    // sequencer, host handshake, irq and trap
    // ---------------------------------------------------------------
    always_comb begin
        st_nxt = st_r;
        st_nxt.rst_sync = {st_r.rst_sync[0], 1'b1};
        st_nxt.trap_sync = {st_r.trap_sync[1:0], i_trap_pin};
        st_nxt.done = 1'b0;
        st_nxt.sload_n = 1'b1;
        st_nxt.early_n = 1'b1;
        st_nxt.cnt = st_r.cnt + dmp_pkg::PHASE_ONE;
        // ready floats after its one high cycle
        if (!st_r.rdy_oe_n && st_r.rdy_n) begin
            st_nxt.rdy_oe_n = 1'b1;
        end
        case (st_r.state)
            dmp_pkg::ST_IDLE: begin
                st_nxt.cnt = dmp_pkg::PHASE_ZERO;
                if (i_host_req) begin
                    st_nxt.state = dmp_pkg::ST_EARLY;
                    st_nxt.early_n = 1'b0;
                    st_nxt.rdy_n = 1'b0;
                    st_nxt.rdy_oe_n = 1'b0;
                    st_nxt.kind = i_host_wr ? dmp_pkg::KIND_HOST_WR
                                            : dmp_pkg::KIND_HOST_RD;
                    st_nxt.addr = i_host_addr;
                    st_nxt.wdata = i_host_wdata;
                    // trap input low: writes go to font plane only
                    st_nxt.wmask = (!i_trap_is_output && trap_low) ?
                        dmp_pkg::FONT_PLANE_MASK :
                        i_host_plane_mask;
                end else if (i_fetch_req) begin
                    st_nxt.state = dmp_pkg::ST_ROW;
                    st_nxt.kind = dmp_pkg::KIND_REFRESH;
                    st_nxt.addr = i_fetch_addr;
                end
            end
            dmp_pkg::ST_EARLY: begin
                st_nxt.state = dmp_pkg::ST_ROW;
                st_nxt.cnt = dmp_pkg::PHASE_ZERO;
            end
            dmp_pkg::ST_ROW: begin
                if (st_r.cnt == dmp_pkg::PHASE_CNT_W'(
                        dmp_pkg::ROW_SETUP_CYC)) begin
                    st_nxt.ras_n = 1'b0;
                end
                if (st_r.cnt == dmp_pkg::PHASE_CNT_W'(
                        dmp_pkg::RAS_HOLD_CYC)) begin
                    st_nxt.state = dmp_pkg::ST_COL;
                    st_nxt.cnt = dmp_pkg::PHASE_ZERO;
                end
            end
            dmp_pkg::ST_COL: begin
                if (st_r.cnt == dmp_pkg::PHASE_ZERO) begin
                    st_nxt.cas_n = 1'b0;
                    if (st_r.kind == dmp_pkg::KIND_HOST_WR) begin
                        st_nxt.we_n = ~st_r.wmask;
                    end else begin
                        st_nxt.plane02_read_en_n_n = st_r.second;
                        st_nxt.plane13_read_en_n_n = ~st_r.second;
                    end
                end
                if (st_r.cnt == dmp_pkg::PHASE_CNT_W'(dmp_pkg::CAS_CYC))
                begin
                    st_nxt.state = dmp_pkg::ST_DONE;
                end
            end
            dmp_pkg::ST_DONE: begin
                // last capture was taken after our column drive let go
                if (st_r.second) begin
                    st_nxt.rdata[15:8]  = bus01.rd_data;
                    st_nxt.rdata[31:24] = bus23.rd_data;
                end else begin
                    st_nxt.rdata[7:0]   = bus01.rd_data;
                    st_nxt.rdata[23:16] = bus23.rd_data;
                end
                // release strobes at cycle end
                st_nxt.ras_n = 1'b1;
                st_nxt.cas_n = 1'b1;
                st_nxt.plane02_read_en_n_n = 1'b1;
                st_nxt.plane13_read_en_n_n = 1'b1;
                st_nxt.we_n = dmp_pkg::ALL_PLANES_OFF;
                st_nxt.cnt = dmp_pkg::PHASE_ZERO;
                if (st_r.kind != dmp_pkg::KIND_HOST_WR && !st_r.second)
                begin
                    // planes 1 and 3 take a second full row cycle
                    st_nxt.second = 1'b1;
                    st_nxt.state = dmp_pkg::ST_ROW;
                end else begin
                    st_nxt.second = 1'b0;
                    st_nxt.state = dmp_pkg::ST_IDLE;
                    if (st_r.kind == dmp_pkg::KIND_REFRESH) begin
                        st_nxt.sload_n = ~i_text_mode;
                    end else begin
                        st_nxt.done = 1'b1;
                        st_nxt.rdy_n = 1'b1;
                    end
                end
            end
            default: st_nxt.state = dmp_pkg::ST_IDLE;
        endcase
        // set wins over the clear
        if (i_irq_clear_wr && !i_irq_clear_bit) begin
            st_nxt.irq_pend = 1'b0;
        end
        if (i_irq_event) begin
            st_nxt.irq_pend = 1'b1;
        end
    end

    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            st_r <= '{rst_sync: 2'h0, state: dmp_pkg::ST_IDLE,
                      kind: dmp_pkg::KIND_REFRESH, cnt: 3'h0,
                      second: 1'b0, addr: '0, wdata: 32'h0,
                      wmask: 4'h0, rdata: 32'h0, done: 1'b0,
                      ras_n: 1'b1, cas_n: 1'b1, plane02_read_en_n_n: 1'b1,
                      plane13_read_en_n_n: 1'b1, we_n: 4'hf, early_n: 1'b1,
                      sload_n: 1'b1, irq_pend: 1'b0, rdy_n: 1'b1,
                      rdy_oe_n: 1'b1, trap_sync: 3'h7};
        end else begin
            st_r <= st_nxt;
        end
    end

    // ---------------------------------------------------------------
    // outputs
    // ---------------------------------------------------------------
    assign o_display_irq      = st_r.irq_pend & i_irq_enable;
    assign o_display_irq_oe_n = ~o_display_irq;
    assign o_ready_n          = st_r.rdy_n;
    assign o_ready_n_oe_n     = st_r.rdy_oe_n;
    assign o_trap_pin         = ~i_trap_request;
    assign o_trap_pin_oe_n    = ~i_trap_is_output;
    assign o_ras_n            = st_r.ras_n;
    assign o_cas_n            = st_r.cas_n;
    assign o_plane02_read_en_n = st_r.plane02_read_en_n_n;
    assign o_plane13_read_en_n = st_r.plane13_read_en_n_n;
    assign o_plane_write_en_n = st_r.we_n;
    assign o_early_mem_en_n   = st_r.early_n;
    assign o_attr_shift_load_n = st_r.sload_n;
    assign o_host_rdata       = st_r.rdata;
    assign o_host_done        = st_r.done;
endmodule

/* tb/display_mem_port_sva.sv */
// checker: port-level assertions for the display memory port
`timescale 1ns/1ns
module display_mem_port_sva #(
    parameter int unsigned ADDR_W = 16
) (
    input wire logic              i_clk,
    input wire logic              i_rstn,
    input wire logic              i_host_wr,
    input wire logic [ADDR_W-1:0] i_host_addr,
    input wire logic [3:0]        i_host_plane_mask,
    input wire logic              i_irq_event,
    input wire logic              i_irq_enable,
    input wire logic              i_irq_clear_bit,
    input wire logic              i_irq_clear_wr,
    input wire logic              i_trap_is_output,
    input wire logic              i_trap_request,
    input wire logic              i_trap_pin,
    input wire logic              o_trap_pin,
    input wire logic              o_trap_pin_oe_n,
    input wire logic              o_host_done,
    input wire logic              o_ready_n,
    input wire logic              o_ready_n_oe_n,
    input wire logic              o_display_irq,
    input wire logic              o_display_irq_oe_n,
    input wire logic [7:0]        o_planes01_bus,
    input wire logic              o_planes01_bus_oe_n,
    input wire logic [7:0]        o_planes23_bus,
    input wire logic              o_planes23_bus_oe_n,
    input wire logic              o_ras_n,
    input wire logic              o_cas_n,
    input wire logic              o_plane02_read_en_n,
    input wire logic              o_plane13_read_en_n,
    input wire logic [3:0]        o_plane_write_en_n,
    input wire logic              o_early_mem_en_n
);
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_rstn);
    // -----------------------------------------------------------------
    // helpers and sequences
    // -----------------------------------------------------------------
    logic host_on;
    logic addr_both;
    // a host cycle is under way while ready is driven low
    assign host_on   = !o_ready_n_oe_n && !o_ready_n;
    assign addr_both = !o_planes01_bus_oe_n && !o_planes23_bus_oe_n
                       && (o_planes01_bus == o_planes23_bus);
    sequence s_ready_release;
        o_ready_n && !o_ready_n_oe_n ##1 o_ready_n_oe_n;
    endsequence
    sequence s_slot_ahead;
        !o_early_mem_en_n && o_ras_n;
    endsequence
    // -----------------------------------------------------------------
    // assertions
    // -----------------------------------------------------------------
    chk_ras_first: assert property ($fell(o_cas_n) |-> !o_ras_n)
        else $error("column strobe fell while row strobe high");
    chk_row_addr: assert property ($fell(o_ras_n) && host_on
        |-> addr_both && o_planes01_bus == i_host_addr[15:8])
        else $error("row address wrong at row strobe fall");
    chk_col_addr: assert property ($fell(o_cas_n) && host_on
        |-> addr_both && o_planes01_bus == i_host_addr[7:0])
        else $error("column address wrong at column strobe fall");
    chk_ready_pulse: assert property (o_host_done |-> s_ready_release)
        else $error("ready not high for one clock then floating");
    chk_ready_starts: assert property ($fell(o_ready_n_oe_n)
        |-> !o_ready_n)
        else $error("ready did not start low");
    chk_early_ahead: assert property ($fell(o_ready_n_oe_n)
        |-> s_slot_ahead)
        else $error("early enable not ahead of the row strobe");
    chk_irq_gate: assert property (!i_irq_enable
        |-> o_display_irq_oe_n)
        else $error("irq driven while disabled");
    chk_irq_float: assert property (!o_display_irq_oe_n
        |-> o_display_irq)
        else $error("irq driven low");
    chk_irq_clear: assert property (i_irq_clear_wr && !i_irq_clear_bit
        && !i_irq_event |=> o_display_irq_oe_n)
        else $error("irq still driven after clear");
    chk_we_mask: assert property (i_trap_pin && i_host_wr
        && host_on |-> (~o_plane_write_en_n & ~i_host_plane_mask) == 4'h0)
        else $error("write enable outside host mask");
    chk_read_pair: assert property (!o_plane02_read_en_n
        |-> o_plane13_read_en_n && !o_ras_n)
        else $error("both read enables low or no row strobe");
    chk_trap_out: assert property (i_trap_is_output
        |-> !o_trap_pin_oe_n && o_trap_pin == !i_trap_request)
        else $error("trap output level wrong");
endmodule
bind display_mem_port display_mem_port_sva #(.ADDR_W(ADDR_W)) u_sva (.*);

/* tb/plane_mem_model.sv */
// model: four planes of display memory on two muxed pair buses
`timescale 1ns/1ns
module plane_mem_model (
    input  wire logic       i_clk,
    input  wire logic       i_ras_n,
    input  wire logic       i_cas_n,
    input  wire logic       i_rd02_n,
    input  wire logic       i_rd13_n,
    input  wire logic [3:0] i_we_n,
    input  wire logic [7:0] i_bus01,
    input  wire logic [7:0] i_bus23,
    output logic      [7:0] o_bus01,
    output logic      [7:0] o_bus23
);
    logic [7:0] mem [int];
    logic [7:0] row_r;
    logic [7:0] col_r;
    logic       ras_d = 1'b1;
    logic       cas_d = 1'b1;
    int         base;
    initial o_bus01 = 8'h00;
    initial o_bus23 = 8'hff;
    // latch strobed addresses, store writes, answer reads a clock later
    always @(posedge i_clk) begin
        if (!i_ras_n && ras_d) row_r = i_bus01;
        if (!i_cas_n && cas_d) col_r = i_bus01;
        ras_d = i_ras_n;
        cas_d = i_cas_n;
        base = {row_r, col_r};
        // last byte seen while the enable is low wins
        for (int p = 0; p < 4; p++)
            if (!i_cas_n && !i_we_n[p])
                mem[p * 65536 + base] = (p < 2) ? i_bus01 : i_bus23;
        if (!i_rd02_n) begin
            o_bus01 <= mem[base];
            o_bus23 <= mem[131072 + base];
        end else if (!i_rd13_n) begin
            o_bus01 <= mem[65536 + base];
            o_bus23 <= mem[196608 + base];
        end else begin
            // released lines toggle so a stale byte is never trusted
            o_bus01 <= ~o_bus01;
            o_bus23 <= ~o_bus23;
        end
    end
endmodule

/* tb/display_mem_port_host_signals_bench.sv */
// bench: directed tests of the display memory port
`timescale 1ns/1ns
module display_mem_port_host_signals_bench;
    logic        i_clk, i_rstn, i_host_req, i_host_wr, i_fetch_req;
    logic        i_text_mode, i_irq_event, i_irq_enable, i_irq_clear_bit;
    logic        i_irq_clear_wr, i_trap_is_output, i_trap_request, trap_ext;
    logic [15:0] i_host_addr, i_fetch_addr;
    logic [3:0]  i_host_plane_mask, o_plane_write_en_n;
    logic [31:0] i_host_wdata, o_host_rdata;
    logic [7:0]  o_planes01_bus, o_planes23_bus, mdl01, mdl23, bus01, bus23;
    logic        o_host_done, o_trap_pin, o_trap_pin_oe_n, i_trap_pin;
    logic        o_ready_n, o_ready_n_oe_n, o_display_irq, o_display_irq_oe_n;
    logic        o_planes01_bus_oe_n, o_planes23_bus_oe_n, o_ras_n, o_cas_n;
    logic        o_plane02_read_en_n, o_plane13_read_en_n, o_early_mem_en_n;
    logic        o_attr_shift_load_n;
    int          miscompares = 0;
    int          checked = 0;
    // wire levels from every party's enable
    assign bus01 = o_planes01_bus_oe_n ? mdl01 : o_planes01_bus;
    assign bus23 = o_planes23_bus_oe_n ? mdl23 : o_planes23_bus;
    assign i_trap_pin = o_trap_pin_oe_n ? trap_ext : o_trap_pin;
    display_mem_port #(.ADDR_W(16)) u_dut (.*, .i_planes01_bus(bus01),
        .i_planes23_bus(bus23));
    plane_mem_model u_mem (.i_clk(i_clk), .i_ras_n(o_ras_n),
        .i_cas_n(o_cas_n), .i_rd02_n(o_plane02_read_en_n),
        .i_rd13_n(o_plane13_read_en_n), .i_we_n(o_plane_write_en_n),
        .i_bus01(bus01), .i_bus23(bus23), .o_bus01(mdl01), .o_bus23(mdl23));
    // -----------------------------------------------------------------
    // helpers
    // -----------------------------------------------------------------
    initial begin
        i_clk = 1'b0;
        forever #20 i_clk = ~i_clk;
    end
    task automatic chk(input string what, input logic [31:0] exp,
                       input logic [31:0] got);
        checked++;
        if (got !== exp) begin
            miscompares++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic report_and_stop;
        $display("checked %0d miscompares %0d", checked, miscompares);
        if (miscompares == 0 && checked > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    // one host access; req dropped in the cycle that shows done
    task automatic access(input logic wr, input logic [15:0] a,
                          input logic [3:0] m, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge i_clk);
        i_host_req <= 1'b1;
        i_host_wr <= wr;
        i_host_addr <= a;
        i_host_plane_mask <= m;
        i_host_wdata <= d;
        do begin
            @(posedge i_clk);
            #1;
            n++;
            if (n > 1 && o_host_done !== 1'b1 && o_ready_n !== 1'b0)
                chk("ready low", 32'h0, {31'h0, o_ready_n});
        end while (o_host_done !== 1'b1 && n < 60);
        i_host_req <= 1'b0;
        chk("done seen", 32'h1, {31'h0, o_host_done});
        chk("ready high", 32'h1, {31'h0, o_ready_n});
        @(posedge i_clk);
        #1;
        chk("ready floats", 32'h1, {31'h0, o_ready_n_oe_n});
    endtask
    // -----------------------------------------------------------------
    // scenarios
    // -----------------------------------------------------------------
    task automatic t_write_read;
        access(1'b1, 16'h1234, 4'hf, 32'h5a5aa5a5);
        access(1'b1, 16'h1234, 4'h5, 32'h3c3cc3c3);
        access(1'b0, 16'h1234, 4'h0, 32'h0);
        chk("read back", 32'h5a3ca5c3, o_host_rdata);
        $display("test write_read done");
    endtask
    task automatic t_trap_in;
        access(1'b1, 16'hbeef, 4'hf, 32'h11112222);
        trap_ext <= 1'b0;
        repeat (4) @(posedge i_clk);
        access(1'b1, 16'hbeef, 4'hf, 32'h77778888);
        trap_ext <= 1'b1;
        repeat (4) @(posedge i_clk);
        access(1'b0, 16'hbeef, 4'h0, 32'h0);
        chk("font plane only", 32'h11772222, o_host_rdata);
        $display("test trap_in done");
    endtask
    task automatic t_trap_out;
        @(posedge i_clk);
        i_trap_is_output <= 1'b1;
        i_trap_request <= 1'b1;
        @(posedge i_clk);
        #1;
        chk("trap low", 32'h0, {31'h0, i_trap_pin});
        i_trap_request <= 1'b0;
        #5;
        chk("trap high", 32'h1, {31'h0, i_trap_pin});
        $display("test trap_out done");
    endtask
    // enable level, retrace event and a clear write carrying the given bit value, all in one cycle
    task automatic irq_step(input logic en, input logic ev, input logic clr,
                            input logic bitv);
        @(posedge i_clk);
        i_irq_enable <= en;
        i_irq_event <= ev;
        i_irq_clear_wr <= clr;
        i_irq_clear_bit <= bitv;
        @(posedge i_clk);
        i_irq_event <= 1'b0;
        i_irq_clear_wr <= 1'b0;
        @(posedge i_clk);
        #1;
    endtask
    task automatic t_irq;
        irq_step(1'b0, 1'b1, 1'b0, 1'b1);
        chk("irq masked", 32'h1, {31'h0, o_display_irq_oe_n});
        irq_step(1'b1, 1'b0, 1'b0, 1'b1);
        chk("irq up", 32'h2, {o_display_irq, o_display_irq_oe_n});
        irq_step(1'b1, 1'b0, 1'b1, 1'b1);
        chk("irq kept", 32'h2, {o_display_irq, o_display_irq_oe_n});
        irq_step(1'b1, 1'b0, 1'b1, 1'b0);
        chk("irq cleared", 32'h1, {31'h0, o_display_irq_oe_n});
        $display("test irq done");
    endtask
    task automatic t_fetch(input logic txt);
        int n;
        n = 0;
        @(posedge i_clk);
        i_text_mode <= txt;
        i_fetch_addr <= 16'h1234;
        i_fetch_req <= 1'b1;
        @(posedge i_clk);
        i_fetch_req <= 1'b0;
        repeat (30) begin
            @(posedge i_clk);
            #1;
            if (o_attr_shift_load_n === 1'b0) n++;
        end
        chk("load pulses", {31'h0, txt}, n);
        chk("fetch data", 32'h5a3ca5c3, o_host_rdata);
        $display("test fetch done");
    endtask
    // -----------------------------------------------------------------
    // main sequence and watchdog
    // -----------------------------------------------------------------
    initial begin
        {i_rstn, i_host_req, i_host_wr, i_fetch_req, i_text_mode} = 5'h00;
        {i_irq_event, i_irq_enable, i_irq_clear_bit, i_irq_clear_wr} = 4'h0;
        {i_trap_is_output, i_trap_request, trap_ext} = 3'h1;
        i_host_addr = 16'h0000;
        i_fetch_addr = 16'h0000;
        i_host_plane_mask = 4'h0;
        i_host_wdata = 32'h00000000;
        repeat (3) @(posedge i_clk);
        i_rstn <= 1'b1;
        repeat (3) @(posedge i_clk);
        t_write_read();
        t_fetch(1'b1);
        t_fetch(1'b0);
        t_trap_in();
        t_trap_out();
        t_irq();
        report_and_stop();
    end
    // all tests need well under a thousand clocks
    initial begin
        repeat (3000) @(posedge i_clk);
        miscompares++;
        report_and_stop();
    end
endmodule
